// [src/hbd_regs.svh]
// Purpose: Timing constants for the H-bridge drive control block.
// Assumes: Times are in nanoseconds; the clock period is 40 ns (25 MHz).
// Notes:   Cycle counts round least times up to whole clock cycles.
`ifndef HBD_REGS_SVH
`define HBD_REGS_SVH

// Clock period in nanoseconds.
`define HBD_CLK_NS        40
// Idle time before low-power standby.
`define HBD_T_STANDBY_NS  1150000
// Fixed chopping off-time.
`define HBD_T_OFF_NS      25000
// Crossover dead time between fast and slow decay.
`define HBD_CROSSOVER_DEAD_TIME_NS      400
// Over-current deglitch time.
`define HBD_OVERCURRENT_DEGLITCH_TIME_NS      2000
// Over-current retry off-time.
`define HBD_T_RETRY_NS    10000000
// Share of the off-time spent in fast decay, in percent.
`define HBD_FAST_PCT      50

// Converts a least time in nanoseconds to whole clock cycles, rounding up.
`define HBD_CYC_UP(t) (((t) + `HBD_CLK_NS - 1) / `HBD_CLK_NS)

`define HBD_STANDBY_CYC   `HBD_CYC_UP(`HBD_T_STANDBY_NS)
`define HBD_OFF_CYC       `HBD_CYC_UP(`HBD_T_OFF_NS)
`define HBD_DEAD_CYC      `HBD_CYC_UP(`HBD_CROSSOVER_DEAD_TIME_NS)
`define HBD_DEGLITCH_CYC  `HBD_CYC_UP(`HBD_OVERCURRENT_DEGLITCH_TIME_NS)
`define HBD_RETRY_CYC     `HBD_CYC_UP(`HBD_T_RETRY_NS)

`endif

// [src/hbd_pkg.sv]
// Purpose: Types shared by the H-bridge drive control block.
// Assumes: Nothing beyond the timing header.
// Notes:   Timing counts live in hbd_regs.svh.
package hbd_pkg;

  // Bridge command decoded from the logic inputs.
  typedef enum logic [1:0] {
    HBD_CMD_COAST,
    HBD_CMD_FWD,
    HBD_CMD_REV,
    HBD_CMD_BRAKE
  } hbd_cmd_e;

  // Phases of one current chopping cycle.
  typedef enum logic [1:0] {
    HBD_ST_DRIVE,
    HBD_ST_FAST,
    HBD_ST_DEAD,
    HBD_ST_SLOW
  } hbd_chop_e;

endpackage

// [src/hbd_core.sv]
// Purpose: Gate control of a brushed DC motor H-bridge with chopping and protection.
// Assumes: All status inputs are asynchronous comparator levels from the analog side.
// Notes:   PHASE_ENABLE selects the phase/enable input variant instead of two inputs.
`timescale 1ns/1ps
`include "hbd_regs.svh"

module hbd_core #(
  parameter bit PHASE_ENABLE = 1'b0,               // Selects phase/enable input variant.
  parameter int STANDBY_CYC  = `HBD_STANDBY_CYC,   // Idle cycles before standby.
  // Default retry, chopping and deglitch timings.
  parameter int RETRY_CYC    = `HBD_RETRY_CYC,     // Over-current retry off cycles.
  parameter int OFF_CYC      = `HBD_OFF_CYC,       // Chopping off-time cycles.
  parameter int DEAD_CYC     = `HBD_DEAD_CYC,      // Crossover dead time cycles.
  parameter int DEGLITCH_CYC = `HBD_DEGLITCH_CYC   // Over-current deglitch cycles.
) (
  input  wire logic mclk,                          // System clock, 25 MHz.
  input  wire logic arst_n,                        // Asynchronous reset, active low.
  input  wire logic drive_input_a,                 // First drive input (two-input variant).
  input  wire logic drive_input_b,                 // Second drive input (two-input variant).
  input  wire logic direction_phase_input,         // Direction input (phase/enable variant).
  input  wire logic bridge_enable_input,           // Enable input (phase/enable variant).
  input  wire logic sense_trip,                    // Low-side sense comparator tripped.
  input  wire logic overcurrent_protection,        // Output current above trip level.
  input  wire logic thermal_shutdown,              // Over-temperature flag with hysteresis.
  input  wire logic supply_undervoltage_lockout,   // Supply below lockout threshold.
  output logic      high_side_a_on,                // High-side gate of output A.
  output logic      low_side_a_on,                 // Low-side gate of output A.
  output logic      high_side_b_on,                // High-side gate of output B.
  output logic      low_side_b_on,                 // Low-side gate of output B.
  output logic      standby_active,                // Device is in low-power standby.
  output logic      charge_pump_on,                // Charge pump and regulator enable.
  output logic      overcurrent_fault              // Over-current retry interval running.
);
  import hbd_pkg::*;

  // Derived chopping phase lengths.
  localparam int FAST_CYC = OFF_CYC * `HBD_FAST_PCT / 100;
  localparam int SLOW_CYC = OFF_CYC - FAST_CYC - DEAD_CYC;
  localparam int CW       = $clog2(OFF_CYC + 1);
  localparam int SW       = $clog2(STANDBY_CYC + 1);
  localparam int RW       = $clog2(RETRY_CYC + 1);
  localparam int DW       = $clog2(DEGLITCH_CYC + 1);

  // Refuse timings that leave no room for a slow decay phase.
  if (FAST_CYC < 1 || DEAD_CYC < 1 || SLOW_CYC < 1 || DEGLITCH_CYC < 1 ||
      RETRY_CYC < 1 || STANDBY_CYC < 1) begin : g_bad_timing
    $error("hbd_core: timing parameters leave an empty phase");
  end

  // Decodes the active input variant into a bridge command.
  function automatic hbd_cmd_e hbd_decode(input logic a, input logic b,
                                          input logic ph, input logic en);
    hbd_cmd_e c;
    c = HBD_CMD_COAST;
    if (PHASE_ENABLE) begin
      // Enable high drives by phase; enable low brakes or coasts by phase.
      if (en) begin
        c = ph ? HBD_CMD_FWD : HBD_CMD_REV;
      end else begin
        c = ph ? HBD_CMD_BRAKE : HBD_CMD_COAST;
      end
    end else begin
      unique case ({a, b})
        2'b10:   c = HBD_CMD_FWD;
        2'b01:   c = HBD_CMD_REV;
        2'b11:   c = HBD_CMD_BRAKE;
        2'b00:   c = HBD_CMD_COAST;
      endcase
    end
    return c;
  endfunction

  // Three-stage synchronisers; a level counts once stages two and three agree.
  logic [7:0] sync1_reg;                           // First stage, read only by stage two.
  logic [7:0] sync2_reg;                           // Second stage.
  logic [7:0] sync3_reg;                           // Third stage.
  logic [7:0] filt_reg;                            // Accepted input levels.

  // Samples the pins through the synchroniser chain.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      sync3_reg <= 8'h00;
      filt_reg  <= 8'h00;
    end else begin
      sync1_reg <= {drive_input_a, drive_input_b, direction_phase_input, bridge_enable_input,
                    sense_trip, overcurrent_protection, thermal_shutdown,
                    supply_undervoltage_lockout};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg  <= (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg ^ sync3_reg));
    end
  end

  // Named views of the accepted levels.
  logic     trip_f;                                // Sense comparator tripped.
  logic     oc_f;                                  // Over-current level.
  logic     th_f;                                  // Over-temperature level.
  logic     uv_f;                                  // Undervoltage level.
  logic     idle;                                  // Standby entry condition holds.
  logic     run;                                   // Bridge may be driven.
  hbd_cmd_e cmd;                                   // Present bridge command.

  assign trip_f = filt_reg[3];
  assign oc_f   = filt_reg[2];
  assign th_f   = filt_reg[1];
  assign uv_f   = filt_reg[0];
  assign cmd    = hbd_decode(filt_reg[7], filt_reg[6], filt_reg[5], filt_reg[4]);
  assign idle   = !trip_f && (PHASE_ENABLE ? !filt_reg[4] : (filt_reg[7:6] == 2'b00));

  logic            standby_reg;                    // Standby state.
  logic            pump_on_reg;                    // Charge pump enable, inverse of standby.
  logic [SW-1:0]   idle_cnt_reg;                   // Cycles the idle condition has held.
  logic            fault_reg;                      // Over-current retry in progress.
  logic [DW-1:0]   oc_cnt_reg;                     // Cycles over-current has held.
  logic [RW-1:0]   retry_cnt_reg;                  // Cycles spent in retry.
  hbd_chop_e       state_reg;                      // Chopping phase.
  logic [CW-1:0]   chop_cnt_reg;                   // Cycles spent in the chopping phase.

  assign run = !standby_reg && !uv_f && !th_f && !fault_reg;

  // Idle timer, standby and charge pump.
  // Standby ends as soon as the idle condition breaks; the controller then waits
  // for the charge pump before chopping, which this block does not police.
  // The pump enable has its own flip-flop so that the output needs no inverter.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      idle_cnt_reg <= '0;
      standby_reg  <= 1'b0;
      pump_on_reg  <= 1'b1;
    end else if (!idle) begin
      idle_cnt_reg <= '0;
      standby_reg  <= 1'b0;
      pump_on_reg  <= 1'b1;
    end else if (idle_cnt_reg == SW'(STANDBY_CYC)) begin
      standby_reg  <= 1'b1;
      pump_on_reg  <= 1'b0;
    end else begin
      idle_cnt_reg <= idle_cnt_reg + 1'b1;
    end
  end

  // Deglitch and retry timing.
  // Undervoltage acts as a reset and clears any pending fault.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      oc_cnt_reg    <= '0;
      retry_cnt_reg <= '0;
      fault_reg     <= 1'b0;
    end else if (uv_f) begin
      oc_cnt_reg    <= '0;
      retry_cnt_reg <= '0;
      fault_reg     <= 1'b0;
    end else if (fault_reg) begin
      oc_cnt_reg <= '0;
      if (retry_cnt_reg == RW'(RETRY_CYC - 1)) begin
        fault_reg     <= 1'b0;
        retry_cnt_reg <= '0;
      end else begin
        retry_cnt_reg <= retry_cnt_reg + 1'b1;
      end
    end else if (!oc_f) begin
      oc_cnt_reg <= '0;
    end else if (oc_cnt_reg == DW'(DEGLITCH_CYC)) begin
      // Over-current held longer than the deglitch time.
      fault_reg  <= 1'b1;
      oc_cnt_reg <= '0;
    end else begin
      oc_cnt_reg <= oc_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg    <= HBD_ST_DRIVE;
      chop_cnt_reg <= '0;
    end else if (!run || !(cmd == HBD_CMD_FWD || cmd == HBD_CMD_REV)) begin
      // Chopping only applies while driving; anything else restarts the latch.
      state_reg    <= HBD_ST_DRIVE;
      chop_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        HBD_ST_DRIVE: begin
          if (trip_f) begin
            state_reg    <= HBD_ST_FAST;
            chop_cnt_reg <= '0;
          end
        end
        HBD_ST_FAST: begin
          if (chop_cnt_reg == CW'(FAST_CYC - 1)) begin
            state_reg    <= HBD_ST_DEAD;
            chop_cnt_reg <= '0;
          end else begin
            chop_cnt_reg <= chop_cnt_reg + 1'b1;
          end
        end
        HBD_ST_DEAD: begin
          if (chop_cnt_reg == CW'(DEAD_CYC - 1)) begin
            state_reg    <= HBD_ST_SLOW;
            chop_cnt_reg <= '0;
          end else begin
            chop_cnt_reg <= chop_cnt_reg + 1'b1;
          end
        end
        HBD_ST_SLOW: begin
          if (chop_cnt_reg == CW'(SLOW_CYC - 1)) begin
            state_reg    <= HBD_ST_DRIVE;
            chop_cnt_reg <= '0;
          end else begin
            chop_cnt_reg <= chop_cnt_reg + 1'b1;
          end
        end
      endcase
    end
  end

  // Gate pattern {hs_a, ls_a, hs_b, ls_b} for the present command and phase.
  logic [3:0] gates_next;
  logic [3:0] gates_reg;

  always_comb begin
    gates_next = 4'h0;
    if (run) begin
      unique case (cmd)
        HBD_CMD_COAST: gates_next = 4'h0;
        HBD_CMD_BRAKE: gates_next = 4'h5;
        HBD_CMD_FWD, HBD_CMD_REV: begin
          unique case (state_reg)
            HBD_ST_DRIVE: gates_next = (cmd == HBD_CMD_FWD) ? 4'h9 : 4'h6;
            HBD_ST_FAST:  gates_next = (cmd == HBD_CMD_FWD) ? 4'h6 : 4'h9;
            HBD_ST_DEAD:  gates_next = 4'h0;
            HBD_ST_SLOW:  gates_next = 4'h5;
          endcase
        end
      endcase
    end
  end

  // Registers the four gate outputs.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gates_reg <= 4'h0;
    end else begin
      gates_reg <= gates_next;
    end
  end

  assign high_side_a_on    = gates_reg[3];
  assign low_side_a_on     = gates_reg[2];
  assign high_side_b_on    = gates_reg[1];
  assign low_side_b_on     = gates_reg[0];
  assign standby_active    = standby_reg;
  assign charge_pump_on    = pump_on_reg;
  assign overcurrent_fault = fault_reg;

  // Helper: length of the present over-current fault.
  logic [RW-1:0] flt_len_reg;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flt_len_reg <= '0;
    end else begin
      flt_len_reg <= fault_reg ? flt_len_reg + 1'b1 : '0;
    end
  end

  sequence trip_in_drive_s;
    run && state_reg == HBD_ST_DRIVE && cmd == HBD_CMD_FWD && trip_f;
  endsequence

  trip_to_fast_a: assert property (@(posedge mclk) disable iff (!arst_n)
    trip_in_drive_s |=> state_reg == HBD_ST_FAST)
    else $error("Sense trip did not start fast decay");
  fast_gates_a: assert property (@(posedge mclk) disable iff (!arst_n)
    run && state_reg == HBD_ST_FAST && cmd == HBD_CMD_FWD |=> gates_reg == 4'h6)
    else $error("Fast decay did not reverse the diagonal");
  fast_length_a: assert property (@(posedge mclk) disable iff (!arst_n)
    state_reg == HBD_ST_DEAD && $past(state_reg) == HBD_ST_FAST
      |-> $past(chop_cnt_reg) == CW'(FAST_CYC - 1))
    else $error("Fast decay length wrong");
  dead_off_a: assert property (@(posedge mclk) disable iff (!arst_n)
    state_reg == HBD_ST_DEAD |=> gates_reg == 4'h0)
    else $error("Drivers on during dead time");
  ocp_off_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fault_reg |=> gates_reg == 4'h0)
    else $error("Bridge on during over-current retry");
  retry_len_a: assert property (@(posedge mclk) disable iff (!arst_n)
    $fell(fault_reg) && !$past(uv_f) |-> $past(flt_len_reg) == RW'(RETRY_CYC - 1))
    else $error("Retry interval length wrong");
  thermal_off_a: assert property (@(posedge mclk) disable iff (!arst_n)
    th_f |=> gates_reg == 4'h0)
    else $error("Bridge on during over-temperature");
  supply_undervoltage_lockout_off_a: assert property (@(posedge mclk) disable iff (!arst_n)
    uv_f |=> gates_reg == 4'h0)
    else $error("Bridge on during undervoltage");
  brake_low_a: assert property (@(posedge mclk) disable iff (!arst_n)
    run && cmd == HBD_CMD_BRAKE |=> gates_reg == 4'h5)
    else $error("Brake did not hold both low sides");
  standby_entry_a: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(standby_reg) |-> $past(idle) && $past(idle_cnt_reg) == SW'(STANDBY_CYC))
    else $error("Standby entered without full idle time");
  pump_standby_a: assert property (@(posedge mclk) disable iff (!arst_n)
    charge_pump_on != standby_active)
    else $error("Charge pump enable disagrees with standby");

endmodule

// [verification/hbd_ctrl_model.sv]
// Purpose: Motor controller model that turns a bridge command into the logic input levels.
// Assumes: The bench changes the command just after a falling clock edge.
// Notes:   Both input variants are driven at once, so both design variants see one command.
`timescale 1ns/1ps

module hbd_ctrl_model (
  input  wire hbd_pkg::hbd_cmd_e cmd,                   // Command chosen by the bench.
  output wire logic              drive_input_a,         // First input, two-input variant.
  output wire logic              drive_input_b,         // Second input, two-input variant.
  output wire logic              direction_phase_input, // Direction input, phase/enable variant.
  output wire logic              bridge_enable_input    // Enable input, phase/enable variant.
);
  import hbd_pkg::*;

  assign drive_input_a = (cmd == HBD_CMD_FWD) || (cmd == HBD_CMD_BRAKE);
  assign drive_input_b = (cmd == HBD_CMD_REV) || (cmd == HBD_CMD_BRAKE);
  // The phase stays high for brake so that the enable-low state brakes instead of coasting.
  assign direction_phase_input = (cmd == HBD_CMD_FWD) || (cmd == HBD_CMD_BRAKE);
  // The enable is high only while the bridge is meant to drive current.
  assign bridge_enable_input = (cmd == HBD_CMD_FWD) || (cmd == HBD_CMD_REV);
endmodule

// [verification/hbd_core_tb.sv]
// Purpose: Self-checking bench for both input variants of the bridge control core.
// Assumes: Short timing parameters; every expected figure is derived from them.
// Notes:   Inputs change at the falling edge and outputs are sampled there too.
`timescale 1ns/1ps

module hbd_core_tb;
  import hbd_pkg::*;

  localparam int STBY = 40;                     // Idle cycles before standby.
  localparam int RTRY = 30;                     // Retry interval cycles.
  localparam int OFFC = 40;                     // Chopping off-time cycles.
  localparam int DEAD = 4;                      // Crossover dead time cycles.
  localparam int DGL  = 5;                      // Over-current deglitch cycles.
  localparam int FAST = OFFC * 50 / 100;        // Fast decay share of the off-time.
  localparam int SLOW = OFFC - FAST - DEAD;     // Slow decay remainder of the off-time.

  logic            mclk = 1'b0;                 // Bench clock.
  logic            arst_n = 1'b0;               // Reset, active low.
  hbd_cmd_e        cmd = HBD_CMD_COAST;         // Command for the controller model.
  logic            trip = 1'b0;                 // Sense comparator level.
  logic            oc = 1'b0;                   // Over-current comparator level.
  logic            hot = 1'b0;                  // Over-temperature flag.
  logic            uv = 1'b0;                   // Supply lockout flag.
  wire             in_a, in_b, ph, en;          // Logic inputs from the model.
  wire [3:0]       g [0:1];                     // Gates {hsA, lsA, hsB, lsB} per variant.
  wire [1:0]       sb, cp, flt;                 // Standby, charge pump, fault per variant.
  int              mismatches = 0;              // Failed comparisons.
  int              tests_run = 0;               // Comparisons made.
  int              n;                           // Measured run length.

  // Free-running clock at 25 MHz.
  always #20 mclk = ~mclk;

  hbd_ctrl_model u_ctrl (.cmd(cmd), .drive_input_a(in_a), .drive_input_b(in_b),
    .direction_phase_input(ph), .bridge_enable_input(en));

  // Index 0 is the two-input variant, index 1 the phase/enable variant.
  for (genvar i = 0; i < 2; i++) begin : gen_var
    hbd_core #(.PHASE_ENABLE(i == 1), .STANDBY_CYC(STBY), .RETRY_CYC(RTRY),
      .OFF_CYC(OFFC), .DEAD_CYC(DEAD), .DEGLITCH_CYC(DGL)) u_dut (
      .mclk(mclk), .arst_n(arst_n), .drive_input_a(in_a), .drive_input_b(in_b),
      .direction_phase_input(ph), .bridge_enable_input(en), .sense_trip(trip),
      .overcurrent_protection(oc), .thermal_shutdown(hot),
      .supply_undervoltage_lockout(uv), .high_side_a_on(g[i][3]),
      .low_side_a_on(g[i][2]), .high_side_b_on(g[i][1]), .low_side_b_on(g[i][0]),
      .standby_active(sb[i]), .charge_pump_on(cp[i]), .overcurrent_fault(flt[i]));
  end

  // Gate pattern that a steady command should give.
  function automatic logic [3:0] exp_gates(input hbd_cmd_e c);
    case (c)
      HBD_CMD_FWD:   return 4'h9;
      HBD_CMD_REV:   return 4'h6;
      HBD_CMD_BRAKE: return 4'h5;
      default:       return 4'h0;
    endcase
  endfunction

  // Compares a gate pattern.
  task automatic chk_gates(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t gates got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares a single status flag.
  task automatic chk_flag(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t flag got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares a measured number of cycles.
  task automatic chk_len(input int got, input int exp);
    tests_run++;
    if (got != exp) begin
      mismatches++;
      $display("[FAIL] t=%0t length got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits a number of falling edges.
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask

  // True while both variants show the masked {fault, gates} pattern.
  function automatic bit both_show(input logic [4:0] exp, input logic [4:0] msk);
    return ((({flt[0], g[0]} & msk) === exp) && (({flt[1], g[1]} & msk) === exp));
  endfunction

  // Waits for a masked {fault, gates} pattern on both variants, then counts how long it stands.
  task automatic run_len(input logic [4:0] exp, input logic [4:0] msk, output int len);
    int w;
    len = 0;
    w = 0;
    while (!both_show(exp, msk) && (w < 400)) begin
      cyc(1);
      w++;
    end
    while (both_show(exp, msk) && (len < 1000)) begin
      cyc(1);
      len++;
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if ((mismatches == 0) && (tests_run > 0)) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Cuts a hang short; the sequence needs a few hundred cycles.
  initial begin
    #(40 * 20000);
    mismatches++;
    test_done;
  end

  // Main sequence.
  initial begin
    void'($urandom(32'h94279bf8));
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    chk_gates(g[0], 4'h0);
    chk_gates(g[1], 4'h0);
    chk_flag(cp[0], 1'b1);
    arst_n = 1'b1;
    cyc(2);
    // Every command in order first, then random ones; a forward step keeps idle short.
    for (int k = 0; k < 12; k++) begin
      cmd = (k < 4) ? hbd_cmd_e'(k) : hbd_cmd_e'($urandom_range(3));
      cyc(6 + $urandom_range(3));
      chk_gates(g[0], exp_gates(cmd));
      chk_gates(g[1], exp_gates(cmd));
      cmd = HBD_CMD_FWD;
      cyc(6);
    end
    // One chopping cycle in each direction, with the phase lengths measured.
    for (int k = 0; k < 2; k++) begin
      cmd = k ? HBD_CMD_REV : HBD_CMD_FWD;
      cyc(10);
      trip = 1'b1;
      cyc(3);
      trip = 1'b0;
      run_len({1'b0, exp_gates(k ? HBD_CMD_FWD : HBD_CMD_REV)}, 5'h1f, n);
      chk_len(n, FAST);
      run_len(5'h00, 5'h1f, n);
      chk_len(n, DEAD);
      run_len(5'h05, 5'h1f, n);
      chk_len(n, SLOW);
      chk_gates(g[0], exp_gates(cmd));
    end
    // A short over-current glitch must be filtered out.
    cmd = HBD_CMD_FWD;
    oc = 1'b1;
    cyc(1 + $urandom_range(2));
    oc = 1'b0;
    cyc(12);
    chk_flag(flt[0], 1'b0);
    // A lasting over-current repeats the retry cycle with the bridge off.
    oc = 1'b1;
    for (int k = 0; k < 2; k++) begin
      run_len(5'h10, 5'h1f, n);
      chk_len(n, RTRY - 1);
    end
    oc = 1'b0;
    cyc(RTRY + 20);
    chk_flag(flt[0], 1'b0);
    chk_flag(flt[1], 1'b0);
    chk_gates(g[0], 4'h9);
    // Over-temperature, then undervoltage, each switching the bridge off.
    for (int k = 0; k < 2; k++) begin
      if (k == 1) begin
        uv = 1'b1;
      end else begin
        hot = 1'b1;
      end
      cyc(8);
      chk_gates(g[0], 4'h0);
      hot = 1'b0;
      uv = 1'b0;
      cyc(8);
      chk_gates(g[0], 4'h9);
    end
    // Idle coast leads to standby after the idle time on both variants.
    cmd = HBD_CMD_COAST;
    n = 0;
    while ((sb[0] !== 1'b1) && (n < 200)) begin
      cyc(1);
      n++;
    end
    chk_flag((n > STBY) && (n < STBY + 10), 1'b1);
    chk_flag(sb[1], 1'b1);
    chk_flag(cp[0], 1'b0);
    chk_flag(cp[1], 1'b0);
    cmd = HBD_CMD_FWD;
    cyc(8);
    chk_flag(cp[0], 1'b1);
    chk_flag(cp[1], 1'b1);
    cyc(20);
    chk_gates(g[0], 4'h9);
    test_done;
  end
endmodule
